// ===== hdl/asr_host.sv
`timescale 1ns/1ps
// ****************************************
// Host controller for async 32K x 16 memory
// ****************************************
module asr_host
   import asr_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              ce,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic [1:0]        req_lane,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   input  wire logic              ret_req,
   output logic                   ret_ready,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_cs_n,
   output logic                   mem_we_n,
   output logic                   mem_oe_n,
   output logic                   low_lane_enable_n,
   output logic                   high_lane_enable_n,
   input  wire logic [DATA_W-1:0] mem_dq_i,
   output logic [DATA_W-1:0]      mem_dq_o,
   output logic                   mem_dq_oe
);

   // ****************************************
   // Cycle plan
   // ****************************************
   // Read, counted from the edge that takes the request:
   //   edge 0  select, output drive and lanes fall, address set
   //   edge 3  word sampled, select and output drive rise
   //   edge 4  turnaround over, idle and ready again
   // Write, counted the same way:
   //   edge 0  select, strobe and lanes fall, data driven
   //   edge 2  strobe rises and ends the write, data still held
   //   edge 3  select rises, data bus released, answer pulsed
   // Every figure comes from the package counts, so a slower part
   // needs new times there only; the walk itself stays the same.
   // A low clock enable stretches each step by the cycles it is
   // low, so memory timing is only ever lengthened, never cut.
   // Limitation: a back-to-back read gives up one cycle to the
   // turnaround, traded for never fighting the memory's drivers.

   // ****************************************
   // State record
   // ****************************************

   typedef struct packed {
      asr_state_e        st;
      logic [CNT_W-1:0]  cnt;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [1:0]        lane;
      logic              cs_n;
      logic              we_n;
      logic              oe_n;
      logic              dq_oe;
      logic              rsp_v;
      logic [DATA_W-1:0] rdata;
   } asr_state_s;

   asr_state_s st_reg;
   asr_state_s st_next;
   logic       rst_n;

   // ****************************************
   // Reset release
   // ****************************************
   asr_sync u_sync (
      .clk        (clk),
      .resetn     (resetn),
      .rst_sync_n (rst_n)
   );

   // ****************************************
   // Request acceptance
   // ****************************************
   // Accept requests only when idle and not retaining
   // Retention outranks a request in the same cycle, so a host
   // lowering the supply never races a write still in flight
   assign req_ready = ce && (st_reg.st == ST_IDLE) && !ret_req;

   // ****************************************
   // Next state
   // ****************************************

   // Pins change only on clock edges, all from one record, so
   // select, strobe, lanes and address never skew between them
   // Next-state logic for the whole controller
   always_comb begin
      st_next = st_reg;
      st_next.rsp_v = 1'b0;
      case (st_reg.st)
         ST_IDLE: begin
            st_next.cs_n  = 1'b1;
            st_next.we_n  = 1'b1;
            st_next.oe_n  = 1'b1;
            st_next.dq_oe = 1'b0;
            if (ret_req) begin
               // Deselect first, then grant retention
               st_next.st  = ST_RET;
               st_next.cnt = CNT_W'(RET_CYC);
            end else if (req_valid) begin
               // Address set with select, never after
               st_next.addr  = req_addr;
               st_next.wdata = req_wdata;
               st_next.lane  = req_lane;
               st_next.cs_n  = 1'b0;
               if (req_write) begin
                  // Strobe, select, lane fall together
                  st_next.st    = ST_WRITE;
                  st_next.we_n  = 1'b0;
                  st_next.dq_oe = 1'b1;
                  st_next.cnt   = CNT_W'(WR_CYC);
               end else begin
                  // Bus already released before output drive
                  st_next.st   = ST_READ;
                  st_next.oe_n = 1'b0;
                  st_next.cnt  = CNT_W'(RD_CYC);
               end
            end
         end
         ST_READ: begin
            // Strobe stays high for the whole read
            // Word is taken on the last count, well past the access
            // time, so address and select settle before sampling
            st_next.cnt = st_reg.cnt - 1'b1;
            if (st_reg.cnt == CNT_W'(1)) begin
               st_next.rdata = mem_dq_i;
               st_next.rsp_v = 1'b1;
               st_next.cs_n  = 1'b1;
               st_next.oe_n  = 1'b1;
               st_next.st    = ST_TURN;
               st_next.cnt   = CNT_W'(TURN_CYC);
            end
         end
         ST_WRITE: begin
            // Cycle covers turn-off plus setup
            st_next.cnt = st_reg.cnt - 1'b1;
            if (st_reg.cnt == CNT_W'(1)) begin
               // Strobe rise ends the write, data held
               st_next.we_n = 1'b1;
               st_next.st   = ST_WEND;
            end
         end
         ST_WEND: begin
            // Deselect and release data one cycle later
            // The extra cycle is the data hold after the strobe rise;
            // ending on the strobe keeps select and strobe apart
            st_next.cs_n  = 1'b1;
            st_next.dq_oe = 1'b0;
            st_next.rsp_v = 1'b1;
            st_next.st    = ST_IDLE;
         end
         ST_TURN: begin
            // Let the memory float the bus before reuse
            // Without it a following write could meet read drivers
            st_next.cnt = st_reg.cnt - 1'b1;
            if (st_reg.cnt <= CNT_W'(1)) begin
               st_next.st = ST_IDLE;
            end
         end
         ST_RET: begin
            // Held deselected until retention request drops
            // Select is forced high here so no stale record value
            // can reselect the part while its supply is lowered
            st_next.cs_n = 1'b1;
            if (st_reg.cnt != CNT_W'(0)) begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end else if (!ret_req) begin
               st_next.st = ST_IDLE;
            end
         end
         default: begin
            // Unused codes fall back to idle; pins keep their values until idle releases them
            st_next.st = ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // State register
   // ****************************************

   // State register with clock enable
   // Reset leaves every strobe high so the memory stays deselected
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg       <= '0;
         st_reg.st    <= ST_IDLE;
         st_reg.cs_n  <= 1'b1;
         st_reg.we_n  <= 1'b1;
         st_reg.oe_n  <= 1'b1;
         st_reg.lane  <= 2'h3;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Pin outputs, all from flip-flops
   // ****************************************
   assign mem_addr           = st_reg.addr;
   assign mem_cs_n           = st_reg.cs_n;
   assign mem_we_n           = st_reg.we_n;
   assign mem_oe_n           = st_reg.oe_n;
   // Lanes low only inside an access
   assign low_lane_enable_n  = st_reg.cs_n | st_reg.lane[0];
   assign high_lane_enable_n = st_reg.cs_n | st_reg.lane[1];
   assign mem_dq_o           = st_reg.wdata;
   assign mem_dq_oe          = st_reg.dq_oe;
   assign rsp_valid          = st_reg.rsp_v;
   assign rsp_rdata          = st_reg.rdata;
   assign ret_ready          = (st_reg.st == ST_RET) &&
                               (st_reg.cnt == CNT_W'(0));

endmodule : asr_host

// ===== hdl/asr_pkg.sv
// Operation
// - All strobes low starts write; any ends
// - Data held stable around ending edge
// - Write cycle covers turn-off plus setup
// - Deselect chip before entering data retention
// - Address valid by select falling edge
// - Write strobe high throughout read cycle
package asr_pkg;

   // ****************************************
   // Geometry
   // ****************************************
   localparam int ADDR_W = 15;
   localparam int DATA_W = 16;
   localparam int LANE_W = 8;

   // ****************************************
   // Timing at 200 MHz, 5 ns period
   // ****************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int READ_CYCLE_TIME_PS = 10000;
   localparam int ACCESS_TIME_PS = 10000;
   localparam int WE_PULSE_PS = 7000;
   localparam int DATA_SETUP_TO_WRITE_END_PS = 5000;
   localparam int WE_LOW_TO_HIGHZ_PS = 5000;
   localparam int OE_HIGH_TO_HIGHZ_PS = 5000;
   localparam int DESELECT_TO_RETENTION_DELAY_PS = 0;
   // Least times round up to whole cycles; read adds one more cycle, and only retention is held to at least one
   localparam int RD_CYC =
      (ACCESS_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
   localparam int WR_CYC_RAW =
      (WE_LOW_TO_HIGHZ_PS + DATA_SETUP_TO_WRITE_END_PS
       + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WE_CYC_RAW =
      (WE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WR_CYC = (WR_CYC_RAW > WE_CYC_RAW) ?
      WR_CYC_RAW : WE_CYC_RAW;
   localparam int TURN_CYC =
      (OE_HIGH_TO_HIGHZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RET_CYC_RAW =
      (DESELECT_TO_RETENTION_DELAY_PS + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int RET_CYC = (RET_CYC_RAW < 1) ? 1 : RET_CYC_RAW;
   localparam int CNT_W = 4;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE,
      ST_WEND,
      ST_TURN,
      ST_RET
   } asr_state_e;

endpackage : asr_pkg

// ===== hdl/asr_sync.sv
`timescale 1ns/1ps
// ****************************************
// Reset release synchroniser
// ****************************************
module asr_sync (
   input  wire logic clk,
   input  wire logic resetn,
   output logic      rst_sync_n
);
   logic [1:0] sync_reg;

   // Assert at once, release after two edges
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_reg <= 2'h0;
      end else begin
         sync_reg <= {sync_reg[0], 1'b1};
      end
   end

   assign rst_sync_n = sync_reg[1];
endmodule : asr_sync

// ===== tb/asr_host_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Pin checks on the host side
// ****************************************
module asr_host_asserts
   import asr_pkg::*;
(
   input wire logic              clk,
   input wire logic              resetn,
   input wire logic              rsp_valid,
   input wire logic              ret_ready,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_cs_n,
   input wire logic              mem_we_n,
   input wire logic              mem_oe_n,
   input wire logic              low_lane_enable_n,
   input wire logic              high_lane_enable_n,
   input wire logic [DATA_W-1:0] mem_dq_o,
   input wire logic              mem_dq_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Strobe, bus and select relations
   read_we_high_a: assert property (!mem_oe_n |-> mem_we_n)
      else $error("write strobe low while outputs on");
   bus_release_a: assert property (!mem_oe_n |-> !mem_dq_oe)
      else $error("host drives bus during read");
   ret_desel_a: assert property (ret_ready |-> mem_cs_n)
      else $error("retention granted while selected");
   addr_hold_a: assert property (!mem_cs_n && !$past(mem_cs_n)
      |-> $stable(mem_addr)) else $error("address moved while selected");
   data_hold_a: assert property ($rose(mem_we_n)
      |-> mem_dq_oe && $stable(mem_dq_o)) else $error("data moved at end");
   write_len_a: assert property ($fell(mem_we_n)
      |-> !mem_we_n [*2] ##1 mem_we_n) else $error("bad write length");
   write_start_a: assert property (!mem_we_n |-> !mem_cs_n
      && mem_dq_oe && !(low_lane_enable_n && high_lane_enable_n))
      else $error("write strobe without select and lane");
   read_answer_a: assert property ($fell(mem_oe_n)
      |-> !mem_oe_n [*3] ##1 (mem_oe_n && rsp_valid))
      else $error("read answer late or early");
   // Main scenarios reached
   cover property ($fell(mem_we_n));
   cover property ($fell(mem_oe_n));
   cover property ($rose(ret_ready));
endmodule : asr_host_asserts

// ===== tb/asr_sram_model.sv
`timescale 1ns/1ps
// ****************************************
// Behavioural 32K x 16 memory
// ****************************************
module asr_sram_model
   import asr_pkg::*;
#(parameter int ACC_NS = ACCESS_TIME_PS / 1000)
(
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              cs_n,
   input  wire logic              we_n,
   input  wire logic              oe_n,
   input  wire logic              lo_n,
   input  wire logic              hi_n,
   input  wire logic [DATA_W-1:0] host_dq,
   input  wire logic              host_oe,
   output logic      [DATA_W-1:0] bus,
   output logic                   clash
);
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] rd_dly;
   logic              wr;
   logic              rd;
   logic              tick = 1'b0;
   // Undriven lanes keep changing so a stale value never reads right
   always #1 tick = ~tick;
   assign wr = !cs_n && !we_n && !(lo_n && hi_n);
   assign rd = !cs_n && !oe_n && we_n;
   assign #(ACC_NS) rd_dly = mem[addr];
   // Store while all strobes overlap
   always @(wr or addr or host_dq or lo_n or hi_n) begin
      if (wr && !lo_n) mem[addr][7:0] = host_dq[7:0];
      if (wr && !hi_n) mem[addr][15:8] = host_dq[15:8];
   end
   // Resolve the shared bus per lane
   always_comb begin
      bus = host_oe ? host_dq : ({16{tick}} ^ 16'h5a5a);
      if (rd && !lo_n) bus[7:0] = rd_dly[7:0];
      if (rd && !hi_n) bus[15:8] = rd_dly[15:8];
      clash = host_oe && rd && !(lo_n && hi_n);
   end
endmodule : asr_sram_model

// ===== tb/asr_host_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module asr_host_tb;
   import asr_pkg::*;
   logic              clk = 1'b0, resetn = 1'b0, ce = 1'b1, clashed = 1'b0;
   logic              req_valid = 1'b0, req_write = 1'b0, ret_req = 1'b0;
   logic              req_ready, rsp_valid, ret_ready, cs_n, we_n, oe_n;
   logic              lo_n, hi_n, dq_oe, clash;
   logic [ADDR_W-1:0] req_addr = 15'h0000, mem_addr;
   logic [DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, dq_o, bus, got;
   logic [1:0]        req_lane = 2'b00;
   int                mismatches = 0, compares = 0, cycles = 0;
   // ****************************************
   // Design, memory and clock
   // ****************************************
   asr_host dut_u (.clk(clk), .resetn(resetn), .ce(ce),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_lane(req_lane),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ret_req(ret_req),
      .ret_ready(ret_ready), .mem_addr(mem_addr), .mem_cs_n(cs_n),
      .mem_we_n(we_n), .mem_oe_n(oe_n), .low_lane_enable_n(lo_n),
      .high_lane_enable_n(hi_n), .mem_dq_i(bus), .mem_dq_o(dq_o),
      .mem_dq_oe(dq_oe));
   asr_sram_model mdl_u (.addr(mem_addr), .cs_n(cs_n), .we_n(we_n),
      .oe_n(oe_n), .lo_n(lo_n), .hi_n(hi_n), .host_dq(dq_o),
      .host_oe(dq_oe), .bus(bus), .clash(clash));
   always #2.5 clk = ~clk;
   always @(posedge clash) clashed = 1'b1;
   // Hang guard, far above the under a hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         print_verdict();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task print_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   // One request held until taken, then its answer
   task xfer(input logic w, input logic [14:0] a, input logic [15:0] d,
             input logic [1:0] l);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      req_lane <= l;
      n = 0;
      do @(negedge clk); while (req_ready !== 1'b1 && ++n < 50);
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 20);
      got = rsp_rdata;
      `CHK(rsp_valid, 1'b1)
   endtask : xfer
   task t_full;
      xfer(1'b1, 15'h7fff, 16'h1234, 2'b00);
      xfer(1'b1, 15'h0000, 16'hbeef, 2'b00);
      xfer(1'b0, 15'h7fff, 16'h0000, 2'b00);
      `CHK(got, 16'h1234)
   endtask : t_full
   task t_lanes;
      xfer(1'b1, 15'h0005, 16'ha5c3, 2'b00);
      xfer(1'b1, 15'h0005, 16'hff11, 2'b10);
      xfer(1'b1, 15'h0005, 16'h22ff, 2'b01);
      xfer(1'b0, 15'h0005, 16'h0000, 2'b00);
      `CHK(got, 16'h2211)
      xfer(1'b0, 15'h0005, 16'h0000, 2'b10);
      `CHK(got[7:0], 8'h11)
      xfer(1'b0, 15'h0005, 16'h0000, 2'b01);
      `CHK(got[15:8], 8'h22)
   endtask : t_lanes
   // Frozen clock enable and retention both hold off a pending
   // write; the old word at that address must survive both
   task t_ret;
      int n;
      @(posedge clk);
      ce <= 1'b0;
      req_valid <= 1'b1;
      req_write <= 1'b1;
      req_addr <= 15'h7fff;
      req_wdata <= 16'hdead;
      req_lane <= 2'b00;
      @(negedge clk);
      `CHK(req_ready, 1'b0)
      `CHK(cs_n, 1'b1)
      @(posedge clk);
      ce <= 1'b1;
      ret_req <= 1'b1;
      n = 0;
      do @(negedge clk); while (ret_ready !== 1'b1 && ++n < 10);
      `CHK(cs_n, 1'b1)
      `CHK(req_ready, 1'b0)
      @(posedge clk);
      ret_req <= 1'b0;
      req_valid <= 1'b0;
      repeat (2) @(negedge clk);
      `CHK(ret_ready, 1'b0)
      xfer(1'b0, 15'h7fff, 16'h0000, 2'b00);
      `CHK(got, 16'h1234)
   endtask : t_ret
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_full();
      t_lanes();
      t_ret();
      `CHK(clashed, 1'b0)
      print_verdict();
   end
endmodule : asr_host_tb
bind asr_host asr_host_asserts chk_u (.clk(clk), .resetn(resetn),
   .rsp_valid(rsp_valid), .ret_ready(ret_ready), .mem_addr(mem_addr),
   .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
   .low_lane_enable_n(low_lane_enable_n), .mem_dq_o(mem_dq_o),
   .high_lane_enable_n(high_lane_enable_n), .mem_dq_oe(mem_dq_oe));
